//--- verilog/adjuster_pkg.sv
package adjuster_pkg;
    // Pulse and wait times in their own units
    localparam int unsigned CLOCK_MHZ = 200;
    localparam int unsigned STEP_PULSE_US = 200;
    localparam int unsigned GAP_US = 10;
    localparam int unsigned PROG_PULSE_US = 300;
    localparam int unsigned PROG_TIME_MS = 100;
    localparam int unsigned RELOAD_US = 1000;
    // Derived cycle counts (least times, rounded up)
    localparam int unsigned STEP_CYCLES = STEP_PULSE_US * CLOCK_MHZ;
    localparam int unsigned GAP_CYCLES = GAP_US * CLOCK_MHZ;
    localparam int unsigned PROG_CYCLES = PROG_PULSE_US * CLOCK_MHZ;
    localparam int unsigned PROG_WAIT_CYCLES = PROG_TIME_MS * 1000 * CLOCK_MHZ;
    localparam int unsigned RELOAD_CYCLES = RELOAD_US * CLOCK_MHZ;
    localparam int unsigned CNT_W = 25;
    // Setting range
    localparam logic [7:0] SETTING_MIN = 8'h01;
    localparam logic [7:0] SETTING_MAX = 8'h80;
    // Control line drive codes
    localparam logic [1:0] LINE_MID = 2'h0;
    localparam logic [1:0] LINE_HIGH = 2'h1;
    localparam logic [1:0] LINE_LOW = 2'h2;
    localparam logic [1:0] LINE_PROG = 2'h3;
    // Commands
    localparam logic [2:0] CMD_UP = 3'h0;
    localparam logic [2:0] CMD_DOWN = 3'h1;
    localparam logic [2:0] CMD_STORE = 3'h2;
    localparam logic [2:0] CMD_RELOAD = 3'h3;
    localparam logic [2:0] CMD_PRIME = 3'h4;
    localparam logic [2:0] CMD_LOCK = 3'h5;
endpackage

//--- verilog/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer import adjuster_pkg::*; #(
    parameter int unsigned WIDTH = CNT_W
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_done
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic done_q;
    logic done_d;

    always_comb begin
        count_d = count_q;
        done_d = 1'b0;
        if (i_load) begin
            count_d = i_count;
        end else if (count_q != '0) begin
            count_d = count_q - 1'b1;
            done_d = (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_q <= '0;
            done_q <= 1'b0;
        end else begin
            count_q <= count_d;
            done_q <= done_d;
        end
    end

    assign o_done = done_q;
endmodule

//--- verilog/setting_adjuster_host.sv
`timescale 1ns/1ps
// How it works
// (R1) Steps and stores are issued only while the enable pin is driven high.
// (R2) An up step drives the line from mid to high for the step pulse time.
// (R3) A down step drives the line from mid to low for the step pulse time.
// (R4) The tracked setting saturates at 1 and 128 and ends never wrap.
// (R5) A store holds the line at programming level beyond the least hold time.
// (R6) After a store the host waits the full programming time before more.
// (R7) The stored copy takes the tracked setting when a store is issued.
// (R8) A reload drops enable low so the device reloads its stored setting.
// (R9) Between actions the line is released to rest at mid level.
// (R10) Every pulse lasts far longer than the rejection width.
// (R11) A prime command gives one dummy pulse the device drops after power-up.
// (R12) The enable pin is held low whenever the host is idle-locked.
// (R13) Enable is driven low from reset, the device's own safe default.
// (R14) A lock command grounds enable before supplies may be removed.
// (R15) Power-down is allowed only once the programming wait has passed; pdok_q resets to 1, so it is also allowed from reset before any store.
// (R16) The tracked setting is kept within 1 to 128 inclusive.
// (R17) The line returns to mid for a gap time after every step pulse; a store is followed by the programming wait.
module setting_adjuster_host import adjuster_pkg::*; #(
    parameter int unsigned STEP_COUNT = STEP_CYCLES,
    parameter int unsigned GAP_COUNT = GAP_CYCLES,
    parameter int unsigned PROG_COUNT = PROG_CYCLES,
    parameter int unsigned PROG_WAIT_COUNT = PROG_WAIT_CYCLES,
    parameter int unsigned RELOAD_COUNT = RELOAD_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_cmd_valid,
    input wire logic [2:0] i_cmd,
    input wire logic [7:0] i_initial_setting,
    output logic o_cmd_ready,
    output logic [1:0] o_control_line,
    output logic o_control_line_oe_n,
    output logic o_enable,
    output logic [7:0] o_setting,
    output logic [7:0] o_stored_setting,
    output logic o_power_down_ok
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_PULSE = 6'h02,
        ST_GAP = 6'h04,
        ST_PROG = 6'h08,
        ST_WAIT = 6'h10,
        ST_RELOAD = 6'h20
    } state_e;

    state_e state_q;
    state_e state_d;
    logic [1:0] line_q;
    logic [1:0] line_d;
    logic oe_n_q;
    logic oe_n_d;
    logic enable_q;
    logic enable_d;
    logic [7:0] setting_q;
    logic [7:0] setting_d;
    logic [7:0] stored_q;
    logic [7:0] stored_d;
    logic ready_q;
    logic ready_d;
    logic pdok_q;
    logic pdok_d;
    logic seeded_q;
    logic seeded_d;
    logic load;
    logic [CNT_W-1:0] load_count;
    logic done;

    cycle_timer #(.WIDTH(CNT_W)) u_timer (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_load(load),
        .i_count(load_count),
        .o_done(done)
    );

    always_comb begin
        state_d = state_q;
        line_d = line_q;
        oe_n_d = oe_n_q;
        enable_d = enable_q;
        setting_d = setting_q;
        stored_d = stored_q;
        ready_d = ready_q;
        pdok_d = pdok_q;
        seeded_d = seeded_q;
        load = 1'b0;
        load_count = '0;
        if (!seeded_q) begin
            seeded_d = 1'b1;
            // (R16) Clamp seed
            if (i_initial_setting < SETTING_MIN) begin
                setting_d = SETTING_MIN;
            end else if (i_initial_setting > SETTING_MAX) begin
                setting_d = SETTING_MAX;
            end else begin
                setting_d = i_initial_setting;
            end
            stored_d = setting_d;
            ready_d = 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (i_cmd_valid && ready_q) begin
                        ready_d = 1'b0;
                        case (i_cmd)
                            CMD_UP, CMD_DOWN, CMD_PRIME: begin
                                // (R1) Enable for steps
                                enable_d = 1'b1;
                                oe_n_d = 1'b0;
                                // (R2) Mid to high
                                line_d = LINE_HIGH;
                                if (i_cmd == CMD_DOWN) begin
                                    // (R3) Mid to low
                                    line_d = LINE_LOW;
                                end
                                // (R4) Saturating track
                                if (i_cmd == CMD_UP &&
                                        setting_q != SETTING_MAX) begin
                                    setting_d = setting_q + 8'h01;
                                end else if (i_cmd == CMD_DOWN &&
                                        setting_q != SETTING_MIN) begin
                                    setting_d = setting_q - 8'h01;
                                end
                                // (R10) Long pulse
                                load = 1'b1;
                                load_count = CNT_W'(STEP_COUNT);
                                state_d = ST_PULSE;
                            end
                            CMD_STORE: begin
                                enable_d = 1'b1;
                                oe_n_d = 1'b0;
                                // (R5) Programming level
                                line_d = LINE_PROG;
                                // (R7) Capture setting
                                stored_d = setting_q;
                                pdok_d = 1'b0;
                                load = 1'b1;
                                load_count = CNT_W'(PROG_COUNT);
                                state_d = ST_PROG;
                            end
                            CMD_RELOAD: begin
                                // (R8) Enable low reloads
                                enable_d = 1'b0;
                                setting_d = stored_q;
                                load = 1'b1;
                                load_count = CNT_W'(RELOAD_COUNT);
                                state_d = ST_RELOAD;
                            end
                            default: begin
                                // (R14) Ground enable
                                enable_d = 1'b0;
                                // (R8) Dropping enable reloads the device
                                setting_d = stored_q;
                                ready_d = 1'b1;
                            end
                        endcase
                    end
                end
                ST_PULSE: begin
                    if (done) begin
                        // (R17) Back to mid
                        line_d = LINE_MID;
                        load = 1'b1;
                        load_count = CNT_W'(GAP_COUNT);
                        state_d = ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (done) begin
                        // (R9) Release to float
                        oe_n_d = 1'b1;
                        ready_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
                ST_PROG: begin
                    if (done) begin
                        line_d = LINE_MID;
                        oe_n_d = 1'b1;
                        // (R6) Programming wait
                        load = 1'b1;
                        load_count = CNT_W'(PROG_WAIT_COUNT);
                        state_d = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (done) begin
                        // (R15) Power-down allowed
                        pdok_d = 1'b1;
                        ready_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
                ST_RELOAD: begin
                    if (done) begin
                        ready_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // (R11) Prime pulse is sent but not counted, shown by no setting change
    // (R12) Enable only rises inside a command; reset and lock keep it low
    // (R13) Safe default from reset
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= ST_IDLE;
            line_q <= LINE_MID;
            oe_n_q <= 1'b1;
            enable_q <= 1'b0;
            setting_q <= SETTING_MIN;
            stored_q <= SETTING_MIN;
            ready_q <= 1'b0;
            pdok_q <= 1'b1;
            seeded_q <= 1'b0;
        end else begin
            state_q <= state_d;
            line_q <= line_d;
            oe_n_q <= oe_n_d;
            enable_q <= enable_d;
            setting_q <= setting_d;
            stored_q <= stored_d;
            ready_q <= ready_d;
            pdok_q <= pdok_d;
            seeded_q <= seeded_d;
        end
    end

    assign o_cmd_ready = ready_q;
    assign o_control_line = line_q;
    assign o_control_line_oe_n = oe_n_q;
    assign o_enable = enable_q;
    assign o_setting = setting_q;
    assign o_stored_setting = stored_q;
    assign o_power_down_ok = pdok_q;
endmodule

//--- bench/adjuster_props.sv
`timescale 1ns/1ps
module adjuster_props import adjuster_pkg::*; (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_cmd_valid,
    input wire logic [2:0] i_cmd,
    input wire logic o_cmd_ready,
    input wire logic [1:0] o_control_line,
    input wire logic o_control_line_oe_n,
    input wire logic o_enable,
    input wire logic [7:0] o_setting,
    input wire logic [7:0] o_stored_setting,
    input wire logic o_power_down_ok
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    logic go;
    assign go = i_cmd_valid && o_cmd_ready;
    a_drive_needs_en: assert property (!o_control_line_oe_n |-> o_enable)
        else $error("line driven while disabled");
    a_up_step: assert property (go && i_cmd == CMD_UP &&
        o_setting < SETTING_MAX |=> o_setting == $past(o_setting) + 8'h01)
        else $error("up step wrong");
    a_down_step: assert property (go && i_cmd == CMD_DOWN &&
        o_setting > SETTING_MIN |=> o_setting == $past(o_setting) - 8'h01)
        else $error("down step wrong");
    a_range_kept: assert property (o_setting >= SETTING_MIN &&
        o_setting <= SETTING_MAX) else $error("setting out of range");
    a_pulse_long: assert property (go && i_cmd == CMD_UP |=>
        (o_control_line == LINE_HIGH && !o_control_line_oe_n)[*8])
        else $error("step pulse too short");
    a_store_copy: assert property (go && i_cmd == CMD_STORE |=>
        o_control_line == LINE_PROG && o_stored_setting == $past(o_setting))
        else $error("store wrong");
    a_store_wait: assert property (go && i_cmd == CMD_STORE |=>
        (!o_power_down_ok && !o_cmd_ready)[*8]) else $error("store wait short");
    a_reload_load: assert property (go && i_cmd == CMD_RELOAD |=>
        !o_enable && o_setting == $past(o_stored_setting))
        else $error("reload wrong");
    a_lock_ground: assert property (go && i_cmd >= CMD_LOCK |=>
        !o_enable && o_cmd_ready && o_setting == $past(o_stored_setting))
        else $error("lock wrong");
    a_idle_released: assert property (o_cmd_ready |->
        o_control_line_oe_n) else $error("line held while idle");
    cover property (go && i_cmd == CMD_UP && o_setting == SETTING_MAX);
    cover property (go && i_cmd == CMD_STORE);
    cover property (go && i_cmd == CMD_RELOAD);
    cover property (go && i_cmd == 3'h7);
endmodule
bind setting_adjuster_host adjuster_props adjuster_props_inst (.i_clock,
    .i_reset_n, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_control_line,
    .o_control_line_oe_n, .o_enable, .o_setting, .o_stored_setting,
    .o_power_down_ok);

//--- bench/adj_device_model.sv
`timescale 1ns/1ps
module adj_device_model import adjuster_pkg::*; #(
    parameter int REJECT = 4,
    parameter int PROG_MIN = 6
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [1:0] i_line,
    input wire logic i_line_oe_n,
    input wire logic i_enable,
    input wire logic [7:0] i_seed,
    output logic [7:0] o_count,
    output logic [7:0] o_memory
);
    logic [1:0] lvl;
    logic first_q;
    logic seeded_q;
    int run;
    assign lvl = i_line_oe_n ? LINE_MID : i_line;
    // Reset stands for power-up; memory seeded by the bench
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_count <= SETTING_MIN;
            o_memory <= SETTING_MIN;
            first_q <= 1'b1;
            seeded_q <= 1'b0;
            run <= 0;
        // Seed taken on the first edge, as the host does
        end else if (!seeded_q) begin
            o_count <= i_seed;
            o_memory <= i_seed;
            seeded_q <= 1'b1;
        end else if (!i_enable) begin
            o_count <= o_memory;
            run <= 0;
        end else if (lvl == LINE_MID) begin
            run <= 0;
        end else begin
            run <= run + 1;
            if (run == REJECT && lvl != LINE_PROG) begin
                if (first_q)
                    first_q <= 1'b0;
                else if (lvl == LINE_HIGH && o_count < SETTING_MAX)
                    o_count <= o_count + 8'h01;
                else if (lvl == LINE_LOW && o_count > SETTING_MIN)
                    o_count <= o_count - 8'h01;
            end
            if (run == PROG_MIN && lvl == LINE_PROG)
                o_memory <= o_count;
        end
    end
endmodule

//--- bench/setting_adjuster_host_tb.sv
`timescale 1ns/1ps
module setting_adjuster_host_tb import adjuster_pkg::*;;
    logic i_clock = 0, i_reset_n = 0, i_cmd_valid = 0, rdy_q = 0;
    logic [2:0] i_cmd = 3'h0;
    logic [7:0] i_initial_setting = 8'h01;
    logic rdy, oe_n, en, pdok;
    logic [1:0] line;
    logic [7:0] set, sto, dcount, dmem, e, st;
    logic [15:0] notes[$];
    int err_total = 0, tests_run = 0, cycles = 0, i;
    integer seed = 32'h6ebe2a53;
    always #2.5 i_clock = ~i_clock;
    setting_adjuster_host #(.STEP_COUNT(8), .GAP_COUNT(4), .PROG_COUNT(10),
        .PROG_WAIT_COUNT(20), .RELOAD_COUNT(8)) setting_adjuster_host_inst (
        .i_clock, .i_reset_n, .i_cmd_valid, .i_cmd, .i_initial_setting,
        .o_cmd_ready(rdy), .o_control_line(line), .o_control_line_oe_n(oe_n),
        .o_enable(en), .o_setting(set), .o_stored_setting(sto),
        .o_power_down_ok(pdok));
    adj_device_model adj_device_model_inst (
        .i_clock, .i_reset_n, .i_line(line), .i_line_oe_n(oe_n),
        .i_enable(en), .i_seed(i_initial_setting), .o_count(dcount),
        .o_memory(dmem));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic send(input logic [2:0] c);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 200) begin
            @(negedge i_clock);
            n++;
        end
        if (n >= 200) begin
            err_total++;
            $display("[ERR] %0t ready never returned", $time);
        end
        i_cmd_valid = 1'b1;
        i_cmd = c;
        @(negedge i_clock);
        i_cmd_valid = 1'b0;
        if (c == CMD_UP && e < SETTING_MAX) e = e + 8'h01;
        if (c == CMD_DOWN && e > SETTING_MIN) e = e - 8'h01;
        if (c == CMD_STORE) st = e;
        if (c == CMD_RELOAD || c >= CMD_LOCK) e = st;
        if (c < CMD_LOCK) notes.push_back({st, e});
    endtask
    // Ready rising marks a finished command
    always @(negedge i_clock) begin
        if (rdy === 1'b1 && rdy_q === 1'b0 && notes.size() > 0) begin
            tests_run++;
            if ({sto, set} !== notes[0] ||
                    {dmem, dcount} !== notes[0] ||
                    pdok !== 1'b1) begin
                err_total++;
                $display("[ERR] %0t got %h %h %b want %h", $time,
                    {sto, set}, {dmem, dcount}, pdok, notes[0]);
            end
            void'(notes.pop_front());
        end
        rdy_q <= rdy;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish;
        end
    end
    initial begin
        i_initial_setting = 8'($random(seed) & 32'h3F) + 8'h01;
        e = i_initial_setting;
        st = e;
        repeat (5) @(negedge i_clock);
        i_reset_n = 1'b1;
        @(negedge i_clock);
        send(CMD_PRIME);
        for (i = 0; i < 140; i++) send(CMD_UP);
        send(CMD_STORE);
        for (i = 0; i < 140; i++) send(CMD_DOWN);
        send(CMD_RELOAD);
        send(CMD_LOCK);
        $display("saturation test done");
        for (i = 0; i < 60; i++)
            send(($random(seed) & 1) ? CMD_UP : CMD_DOWN);
        send(3'h7);
        send(CMD_STORE);
        send(CMD_RELOAD);
        $display("random test done");
        i = 0;
        while (notes.size() > 0 && i < 100) begin
            @(negedge i_clock);
            i++;
        end
        if (notes.size() > 0) begin
            err_total++;
            $display("[ERR] %0t results missing", $time);
        end
        tally_and_finish;
    end
endmodule
